// file: rtl/dsag_pkg.sv
// package: shared constants and carrier types for the data-space address generator
package dsag_pkg;
    // ------------------------------------------------------------
    // memory map
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 16;
    localparam int          DATA_W      = 16;
    localparam int          NEAR_W      = 13;
    localparam logic [15:0] SFR_LAST    = 16'h07ff;
    localparam logic [15:0] NEAR_LAST   = 16'h1fff;
    localparam logic [15:0] RAM_BASE    = 16'h0800;
    localparam logic [15:0] RAM_LAST    = 16'h17ff;
    localparam logic [15:0] DPR_BASE    = 16'h1800;
    localparam logic [15:0] DPR_LAST    = 16'h1fff;
    localparam int          DPR_WORDS   = 1024;
    localparam int          DPR_AW      = 10;
    localparam int          NUM_WREG    = 16;
    localparam logic [15:0] INC_WORD    = 16'h0002;
    localparam logic [15:0] INC_BYTE    = 16'h0001;
    localparam logic [15:0] RESET_ZERO  = 16'h0000;

    // absolute and pointer addressing modes
    typedef enum logic [2:0] {
        DSAG_AM_DIRECT  = 3'b000,
        DSAG_AM_IND     = 3'b001,
        DSAG_AM_POSTINC = 3'b010,
        DSAG_AM_POSTDEC = 3'b011,
        DSAG_AM_PREINC  = 3'b100,
        DSAG_AM_PREDEC  = 3'b101,
        DSAG_AM_NEAR    = 3'b110
    } dsag_mode_t;

    // address target
    typedef enum logic [1:0] {
        DSAG_TG_SFR  = 2'b00,
        DSAG_TG_RAM  = 2'b01,
        DSAG_TG_DPR  = 2'b10,
        DSAG_TG_NONE = 2'b11
    } dsag_tgt_t;

    // one access request from the pipeline
    typedef struct packed {
        logic        valid;
        logic        byte_op;
        dsag_mode_t  mode;
        logic [3:0]  wreg;
        logic [15:0] abs_addr;
        logic [15:0] wdata;
    } dsag_req_t;

    // pointer update back to the working register file
    typedef struct packed {
        logic        valid;
        logic [3:0]  wreg;
        logic [15:0] value;
    } dsag_wb_t;

    // an external bus access (main data bus / peripheral bus / dma bus)
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } dsag_bus_t;
endpackage

// file: rtl/dsag_dpram.sv
// module: dual-port word memory with registered read data on both ports
`timescale 1ns/100ps
module dsag_dpram #(
    parameter int WORDS = dsag_pkg::DPR_WORDS,
    parameter int AW    = dsag_pkg::DPR_AW
) (
    // clock
    input  wire logic          ref_clk,
    // port a (cpu)
    input  wire logic          a_rd,
    input  wire logic          a_wr,
    input  wire logic [AW-1:0] a_addr,
    input  wire logic [1:0]    a_be,
    input  wire logic [15:0]   a_wdata,
    output logic      [15:0]   a_rdata,
    // port b (dma)
    input  wire logic          b_rd,
    input  wire logic          b_wr,
    input  wire logic [AW-1:0] b_addr,
    input  wire logic [1:0]    b_be,
    input  wire logic [15:0]   b_wdata,
    output logic      [15:0]   b_rdata
);
    initial begin
        if (WORDS > (1 << AW) || WORDS < 2) begin
            $error("dsag_dpram: bad size");
        end
    end

    // ------------------------------------------------------------
    // one memory per byte lane, both ports; same-lane clash goes to port a
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            logic [7:0] mem [WORDS];
            // lane writes, then registered read data held between reads
            always_ff @(posedge ref_clk) begin
                if (b_wr && b_be[g] && !(a_wr && a_be[g] && a_addr == b_addr)) begin
                    mem[b_addr] <= b_wdata[g*8 +: 8];
                end
                if (a_wr && a_be[g]) begin
                    mem[a_addr] <= a_wdata[g*8 +: 8];
                end
                if (a_rd) begin
                    a_rdata[g*8 +: 8] <= mem[a_addr];
                end
                if (b_rd) begin
                    b_rdata[g*8 +: 8] <= mem[b_addr];
                end
            end
        end
    endgenerate
endmodule

// file: rtl/dsag_core.sv
// module: data-space read/write address generation, steering and dual-port ram
// Functional notes
// - data space is 16-bit words over one linear 64 KB byte range.
// - byte addresses 0x0000..0x07ff select special function registers.
// - 13-bit absolute field in file-register ops reaches 0x0000..0x1fff.
// - any working register may serve as read or write pointer.
// - unimplemented address reads zero and writes have no effect.
// - unimplemented address access raises an address error trap.
// - on trap, pointer and memory stay as before the faulting access.
// - read and write generators run independently but share the buses; a write takes over a read's bus.
// - read address computed in prior cycle, driven at cycle start.
// - write address computed from cycle start, driven in write phase.
// - word accesses ignore address bit 0.
// - little-endian words: low byte even address, high byte odd.
// - byte access picks byte by bit 0, returned on low 8 bits.
// - word post-increment advances pointer by 2.
// - cpu and dma reach dual-port ram together without stalls.
// - dma uses ram port 2 over its own bus; it has no path to the peripherals.
// - cpu uses main bus for ram, peripheral bus for registers.
`timescale 1ns/100ps
module dsag_core #(
    parameter logic [15:0] RAM_LAST_ADDR = dsag_pkg::RAM_LAST,
    parameter int          DPR_WORDS     = dsag_pkg::DPR_WORDS
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    // working register file values
    input  wire logic [16*16-1:0]    wreg_file,
    // read request (prefetched instruction) and result
    input  wire dsag_pkg::dsag_req_t rd_req,
    output dsag_pkg::dsag_wb_t       rd_wb,
    output logic                     rd_valid,
    output logic [15:0]              rd_data,
    // write request and pointer writeback
    input  wire dsag_pkg::dsag_req_t wr_req,
    output dsag_pkg::dsag_wb_t       wr_wb,
    // main data bus (ordinary ram)
    output dsag_pkg::dsag_bus_t      ram_bus,
    input  wire logic [15:0]         ram_rdata,
    // peripheral bus (special function registers)
    output dsag_pkg::dsag_bus_t      per_bus,
    input  wire logic [15:0]         per_rdata,
    // dma bus (port 2 of dual-port ram)
    input  wire dsag_pkg::dsag_bus_t dma_bus,
    output logic [15:0]              dma_rdata,
    // address error trap
    output logic                     addr_trap
);
    initial begin
        if (RAM_LAST_ADDR < dsag_pkg::RAM_BASE || RAM_LAST_ADDR >= dsag_pkg::DPR_BASE
            || DPR_WORDS > (1 << dsag_pkg::DPR_AW)) begin
            $error("dsag_core: bad memory sizes");
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        dsag_pkg::dsag_bus_t rd_bus;   // read address phase, driven at cycle start
        dsag_pkg::dsag_tgt_t rd_tgt;
        logic                rd_hi;    // odd byte read
        logic                rd_byte;

        // read data phase
        logic                rd_pend;  // data returns this cycle
        dsag_pkg::dsag_tgt_t rd_tgt2;
        logic                rd_hi2;
        logic                rd_byte2;

        // read results
        dsag_pkg::dsag_wb_t  rd_wb;
        logic                rd_valid;
        logic [15:0]         rd_data;

        // bus strobes
        dsag_pkg::dsag_bus_t ram_bus;
        dsag_pkg::dsag_bus_t per_bus;
        dsag_pkg::dsag_bus_t dpr_bus;

        // write results and address trap (read or write)
        dsag_pkg::dsag_wb_t  wr_wb;
        logic                trap;
    } dsag_state_t;

    dsag_state_t s_q;
    dsag_state_t s_d;

    logic [15:0] dpr_rdata;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // classify an address into its target region
    function automatic dsag_pkg::dsag_tgt_t classify(input logic [15:0] a);
        dsag_pkg::dsag_tgt_t t;
        t = dsag_pkg::DSAG_TG_NONE;
        if (a <= dsag_pkg::SFR_LAST) begin
            t = dsag_pkg::DSAG_TG_SFR;
        end else if (a <= RAM_LAST_ADDR) begin
            t = dsag_pkg::DSAG_TG_RAM;
        end else if (a >= dsag_pkg::DPR_BASE
                     && a < dsag_pkg::DPR_BASE + 16'(2 * DPR_WORDS)) begin
            t = dsag_pkg::DSAG_TG_DPR;
        end
        return t;
    endfunction

    // pointer step by access size
    function automatic logic [15:0] step(input logic byte_op);
        return byte_op ? dsag_pkg::INC_BYTE : dsag_pkg::INC_WORD;
    endfunction

    // effective address and updated pointer for one request
    function automatic logic [31:0] gen(input dsag_pkg::dsag_req_t r,
                                        input logic [16*16-1:0] wf);
        logic [15:0] p;
        logic [15:0] ea; // 64 KB byte address
        logic [15:0] np;
        p  = wf[r.wreg*16 +: 16];
        ea = p;
        np = p;
        case (r.mode)
            dsag_pkg::DSAG_AM_DIRECT:  ea = r.abs_addr;
            dsag_pkg::DSAG_AM_NEAR:    ea = {3'h0, r.abs_addr[dsag_pkg::NEAR_W-1:0]};
            dsag_pkg::DSAG_AM_IND:     ea = p;
            dsag_pkg::DSAG_AM_POSTINC: np = p + step(r.byte_op);
            dsag_pkg::DSAG_AM_POSTDEC: np = p - step(r.byte_op);
            dsag_pkg::DSAG_AM_PREINC: begin
                np = p + step(r.byte_op);
                ea = np;
            end
            dsag_pkg::DSAG_AM_PREDEC: begin
                np = p - step(r.byte_op);
                ea = np;
            end
            default:                   ea = p;
        endcase
        if (!r.byte_op) begin
            ea[0] = 1'b0;
        end
        return {ea, np};
    endfunction

    // pointer writeback happens only for modifying modes
    function automatic logic modifies(input dsag_pkg::dsag_mode_t m);
        return m inside {dsag_pkg::DSAG_AM_POSTINC, dsag_pkg::DSAG_AM_POSTDEC,
                         dsag_pkg::DSAG_AM_PREINC, dsag_pkg::DSAG_AM_PREDEC};
    endfunction

    // byte enables for a word or one byte lane
    function automatic logic [1:0] lanes(input logic byte_op, input logic hi);
        return byte_op ? (hi ? 2'b10 : 2'b01) : 2'b11;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0]         rg;
        logic [31:0]         wg;
        dsag_pkg::dsag_tgt_t wt;
        logic [15:0]         raw;
        logic [15:0]         wd;
        rg  = gen(rd_req, wreg_file);
        wg  = gen(wr_req, wreg_file);
        wt  = classify(wg[31:16]);
        raw = 16'h0000;
        wd  = wr_req.wdata;
        s_d = s_q;

        // read generator: computed now from prefetched op, driven next cycle
        s_d.rd_bus.rd    = rd_req.valid;
        s_d.rd_bus.wr    = 1'b0;
        s_d.rd_bus.addr  = rg[31:16];
        s_d.rd_bus.be    = lanes(rd_req.byte_op, rg[16]);
        s_d.rd_bus.wdata = 16'h0000;
        s_d.rd_tgt       = classify(rg[31:16]);
        s_d.rd_hi        = rg[16];
        s_d.rd_byte      = rd_req.byte_op;

        // pointer update, dropped when the read address is unimplemented
        s_d.rd_wb.valid  = rd_req.valid && modifies(rd_req.mode)
                           && classify(rg[31:16]) != dsag_pkg::DSAG_TG_NONE;
        s_d.rd_wb.wreg   = rd_req.wreg;
        s_d.rd_wb.value  = rg[15:0];

        // read data phase one cycle after address phase
        s_d.rd_pend  = s_q.rd_bus.rd;
        s_d.rd_tgt2  = s_q.rd_tgt;
        s_d.rd_hi2   = s_q.rd_hi;
        s_d.rd_byte2 = s_q.rd_byte;

        // pick the answering bus
        case (s_q.rd_tgt2)
            dsag_pkg::DSAG_TG_SFR:  raw = per_rdata;
            dsag_pkg::DSAG_TG_RAM:  raw = ram_rdata;
            dsag_pkg::DSAG_TG_DPR:  raw = dpr_rdata;
            default:                raw = 16'h0000;
        endcase

        // byte reads come back zero-extended
        s_d.rd_valid = s_q.rd_pend;
        if (s_q.rd_pend) begin
            s_d.rd_data = s_q.rd_byte2 ? {8'h00, (s_q.rd_hi2 ? raw[15:8] : raw[7:0])}
                                       : raw;
        end

        // write generator: computed at cycle start, driven in write phase
        if (wr_req.byte_op) begin
            wd = {wr_req.wdata[7:0], wr_req.wdata[7:0]};
        end

        // read strobe on the owning bus only
        s_d.ram_bus = '0;
        s_d.per_bus = '0;
        s_d.dpr_bus = '0;
        s_d.ram_bus.rd   = s_d.rd_bus.rd && s_d.rd_tgt == dsag_pkg::DSAG_TG_RAM;
        s_d.per_bus.rd   = s_d.rd_bus.rd && s_d.rd_tgt == dsag_pkg::DSAG_TG_SFR;
        s_d.dpr_bus.rd   = s_d.rd_bus.rd && s_d.rd_tgt == dsag_pkg::DSAG_TG_DPR;
        s_d.ram_bus.addr = s_d.rd_bus.addr;
        s_d.per_bus.addr = s_d.rd_bus.addr;
        s_d.dpr_bus.addr = s_d.rd_bus.addr;
        s_d.ram_bus.be   = s_d.rd_bus.be;
        s_d.per_bus.be   = s_d.rd_bus.be;
        s_d.dpr_bus.be   = s_d.rd_bus.be;

        // a write takes over its bus
        if (wr_req.valid) begin
            case (wt)
                dsag_pkg::DSAG_TG_SFR: begin
                    s_d.per_bus = '{rd: 1'b0, wr: 1'b1, addr: wg[31:16],
                                    be: lanes(wr_req.byte_op, wg[16]), wdata: wd};
                end
                dsag_pkg::DSAG_TG_RAM: begin
                    s_d.ram_bus = '{rd: 1'b0, wr: 1'b1, addr: wg[31:16],
                                    be: lanes(wr_req.byte_op, wg[16]), wdata: wd};
                end
                dsag_pkg::DSAG_TG_DPR: begin
                    s_d.dpr_bus = '{rd: 1'b0, wr: 1'b1, addr: wg[31:16],
                                    be: lanes(wr_req.byte_op, wg[16]), wdata: wd};
                end
                default: ;
            endcase
        end

        // pointer update, dropped when the write address is unimplemented
        s_d.wr_wb.valid = wr_req.valid && modifies(wr_req.mode)
                          && wt != dsag_pkg::DSAG_TG_NONE;
        s_d.wr_wb.wreg  = wr_req.wreg;
        s_d.wr_wb.value = wg[15:0];

        // trap on any unimplemented access
        s_d.trap = (rd_req.valid && classify(rg[31:16]) == dsag_pkg::DSAG_TG_NONE)
                   || (wr_req.valid && wt == dsag_pkg::DSAG_TG_NONE);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // dual-port ram: cpu on port 1, dma on port 2
    // ------------------------------------------------------------
    dsag_dpram #(
        .WORDS (DPR_WORDS),
        .AW    (dsag_pkg::DPR_AW)
    ) u_dpram (
        .ref_clk (ref_clk),
        .a_rd    (s_q.dpr_bus.rd),
        .a_wr    (s_q.dpr_bus.wr),
        .a_addr  (s_q.dpr_bus.addr[dsag_pkg::DPR_AW:1]),
        .a_be    (s_q.dpr_bus.be),
        .a_wdata (s_q.dpr_bus.wdata),
        .a_rdata (dpr_rdata),
        .b_rd    (dma_bus.rd),
        .b_wr    (dma_bus.wr),
        .b_addr  (dma_bus.addr[dsag_pkg::DPR_AW:1]),
        .b_be    (dma_bus.be),
        .b_wdata (dma_bus.wdata),
        .b_rdata (dma_rdata)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_wb     = s_q.rd_wb;
    assign rd_valid  = s_q.rd_valid;
    assign rd_data   = s_q.rd_data;
    assign wr_wb     = s_q.wr_wb;
    assign ram_bus   = s_q.ram_bus;
    assign per_bus   = s_q.per_bus;
    assign addr_trap = s_q.trap;
endmodule

// file: verif/dsag_monitor.sv
// checker: port-level timing and steering properties of the address generator core
`timescale 1ns/100ps
module dsag_monitor #(
    parameter logic [15:0] RAM_LAST_ADDR = dsag_pkg::RAM_LAST,
    parameter int          DPR_WORDS     = dsag_pkg::DPR_WORDS
) (
    // clock and reset
    input wire logic                ref_clk,
    input wire logic                reset_n,
    // cpu side
    input wire logic [16*16-1:0]    wreg_file,
    input wire dsag_pkg::dsag_req_t rd_req,
    input wire dsag_pkg::dsag_wb_t  rd_wb,
    input wire logic                rd_valid,
    input wire logic [15:0]         rd_data,
    input wire dsag_pkg::dsag_req_t wr_req,
    input wire dsag_pkg::dsag_wb_t  wr_wb,
    // buses and trap
    input wire dsag_pkg::dsag_bus_t ram_bus,
    input wire logic [15:0]         ram_rdata,
    input wire dsag_pkg::dsag_bus_t per_bus,
    input wire logic [15:0]         per_rdata,
    input wire dsag_pkg::dsag_bus_t dma_bus,
    input wire logic [15:0]         dma_rdata,
    input wire logic                addr_trap
);
    localparam int UNIMP = 'h1800 + 2 * DPR_WORDS;
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    // pointer values selected by each request
    logic [15:0] rptr;
    logic [15:0] wptr;
    logic        rd_ram;
    logic        wr_ram;
    assign rptr   = wreg_file[16*rd_req.wreg +: 16];
    assign wptr   = wreg_file[16*wr_req.wreg +: 16];
    assign rd_ram = rd_req.abs_addr >= dsag_pkg::RAM_BASE && rd_req.abs_addr <= RAM_LAST_ADDR;
    assign wr_ram = wr_req.abs_addr >= dsag_pkg::RAM_BASE && wr_req.abs_addr <= RAM_LAST_ADDR;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_WORD_ALIGN: assert property ((ram_bus.rd || ram_bus.wr) && ram_bus.be == 2'b11 |->
        !ram_bus.addr[0]) else $error("word access on odd address");
    AST_BYTE_LANE: assert property ((ram_bus.rd || ram_bus.wr) && ram_bus.be != 2'b11 |->
        ram_bus.be == (ram_bus.addr[0] ? 2'b10 : 2'b01)) else $error("byte lane mismatch");
    AST_RAM_RANGE: assert property (ram_bus.rd || ram_bus.wr |->
        ram_bus.addr >= dsag_pkg::RAM_BASE && ram_bus.addr <= RAM_LAST_ADDR)
        else $error("main bus outside ram");
    AST_PER_RANGE: assert property (per_bus.rd || per_bus.wr |->
        per_bus.addr <= dsag_pkg::SFR_LAST) else $error("peripheral bus outside sfr range");
    AST_TRAP: assert property (rd_req.valid && rd_req.mode == dsag_pkg::DSAG_AM_DIRECT
        && int'(rd_req.abs_addr) >= UNIMP && !wr_req.valid |=>
        addr_trap && !ram_bus.rd && !per_bus.rd && !rd_wb.valid) else $error("no trap");
    AST_RD_LAT: assert property (rd_req.valid && rd_req.mode == dsag_pkg::DSAG_AM_DIRECT
        && rd_ram && !wr_req.valid |=> ram_bus.rd && (ram_bus.addr >> 1) ==
        ($past(rd_req.abs_addr) >> 1) ##2 rd_valid) else $error("read timing wrong");
    AST_RD_WORD: assert property (ram_bus.rd && ram_bus.be == 2'b11 |-> ##2
        rd_valid && rd_data == $past(ram_rdata)) else $error("word read data wrong");
    AST_RD_BYTE: assert property (ram_bus.rd && ram_bus.be == 2'b10 |-> ##2
        rd_valid && rd_data == ($past(ram_rdata) >> 8)) else $error("odd byte not on low lane");
    AST_POSTINC: assert property (rd_req.valid && rd_req.mode == dsag_pkg::DSAG_AM_POSTINC
        && !rd_req.byte_op && rptr >= dsag_pkg::RAM_BASE && rptr <= RAM_LAST_ADDR
        && !wr_req.valid |=> rd_wb.valid && rd_wb.wreg == $past(rd_req.wreg)
        && rd_wb.value == $past(rptr) + 16'h0002) else $error("word step not two");
    AST_POSTDEC: assert property (wr_req.valid && wr_req.mode == dsag_pkg::DSAG_AM_POSTDEC
        && wr_req.byte_op && wptr >= dsag_pkg::RAM_BASE && wptr <= RAM_LAST_ADDR |=>
        wr_wb.valid && wr_wb.value == $past(wptr) - 16'h0001) else $error("byte step not one");
    AST_WR_PHASE: assert property (wr_req.valid && wr_req.mode == dsag_pkg::DSAG_AM_DIRECT
        && wr_ram && !wr_req.byte_op |=> ram_bus.wr && ram_bus.be == 2'b11
        && ram_bus.wdata == $past(wr_req.wdata)) else $error("write phase wrong");
endmodule
bind dsag_core dsag_monitor #(.RAM_LAST_ADDR(RAM_LAST_ADDR), .DPR_WORDS(DPR_WORDS)) u_mon (
    .ref_clk(ref_clk), .reset_n(reset_n), .wreg_file(wreg_file), .rd_req(rd_req),
    .rd_wb(rd_wb), .rd_valid(rd_valid), .rd_data(rd_data), .wr_req(wr_req), .wr_wb(wr_wb),
    .ram_bus(ram_bus), .ram_rdata(ram_rdata), .per_bus(per_bus), .per_rdata(per_rdata),
    .dma_bus(dma_bus), .dma_rdata(dma_rdata), .addr_trap(addr_trap));

// file: verif/dsag_mem_model.sv
// partner: word memory answering one data bus, lanes chosen by byte enables
`timescale 1ns/100ps
module dsag_mem_model (
    // clock
    input wire logic                ref_clk,
    // bus from the core
    input wire dsag_pkg::dsag_bus_t bus,
    output logic [15:0]             rdata
);
    logic [15:0] mem [0:32767];
    // read data in the cycle after the strobe, inverted otherwise; lane writes
    always @(posedge ref_clk) begin
        rdata <= bus.rd ? mem[bus.addr[15:1]] : ~rdata;
        if (bus.wr && bus.be[0]) mem[bus.addr[15:1]][7:0] <= bus.wdata[7:0];
        if (bus.wr && bus.be[1]) mem[bus.addr[15:1]][15:8] <= bus.wdata[15:8];
    end
endmodule

// file: verif/tb.sv
// testbench: directed scenarios for the data-space address generator core
`timescale 1ns/100ps
module tb;
    logic                ref_clk = 1'b0;
    logic                reset_n = 1'b0;
    logic [16*16-1:0]    wreg_file = '0;
    dsag_pkg::dsag_req_t rd_req = '0;
    dsag_pkg::dsag_req_t wr_req = '0;
    dsag_pkg::dsag_bus_t dma_bus = '0;
    dsag_pkg::dsag_bus_t ram_bus;
    dsag_pkg::dsag_bus_t per_bus;
    dsag_pkg::dsag_wb_t  rd_wb;
    dsag_pkg::dsag_wb_t  wr_wb;
    logic                rd_valid;
    logic                addr_trap;
    logic [15:0]         rd_data;
    logic [15:0]         ram_rdata;
    logic [15:0]         per_rdata;
    logic [15:0]         dma_rdata;
    logic [15:0]         g_data;
    logic [15:0]         g_wb;
    logic [3:0]          g_bus;
    logic                g_trap;
    logic                g_wbv;
    int                  mismatches = 0;
    int                  checks = 0;
    // ------------------------------------------------------------
    // clock, design and partners
    // ------------------------------------------------------------
    always #4 ref_clk = ~ref_clk;
    dsag_core DUT (.ref_clk(ref_clk), .reset_n(reset_n), .wreg_file(wreg_file),
        .rd_req(rd_req), .rd_wb(rd_wb), .rd_valid(rd_valid), .rd_data(rd_data),
        .wr_req(wr_req), .wr_wb(wr_wb), .ram_bus(ram_bus), .ram_rdata(ram_rdata),
        .per_bus(per_bus), .per_rdata(per_rdata), .dma_bus(dma_bus),
        .dma_rdata(dma_rdata), .addr_trap(addr_trap));
    dsag_mem_model ram_m (.ref_clk(ref_clk), .bus(ram_bus), .rdata(ram_rdata));
    dsag_mem_model per_m (.ref_clk(ref_clk), .bus(per_bus), .rdata(per_rdata));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // one request held for one edge, outputs gathered for four cycles
    task automatic acc(input logic w, input logic b, input dsag_pkg::dsag_mode_t m,
                       input logic [3:0] r, input logic [15:0] a, input logic [15:0] d);
        dsag_pkg::dsag_req_t q;
        q = '{1'b1, b, m, r, a, d};
        g_data = 16'hffff;
        g_trap = 1'b0;
        g_wbv = 1'b0;
        g_wb = 16'h0000;
        g_bus = 4'h0;
        @(posedge ref_clk);
        if (w) wr_req <= q;
        else rd_req <= q;
        @(posedge ref_clk);
        wr_req.valid <= 1'b0;
        rd_req.valid <= 1'b0;
        repeat (4) begin
            #1;
            g_bus = g_bus | {per_bus.wr, per_bus.rd, ram_bus.wr, ram_bus.rd};
            if (addr_trap === 1'b1) g_trap = 1'b1;
            if (rd_wb.valid === 1'b1) {g_wbv, g_wb} = {1'b1, rd_wb.value};
            if (wr_wb.valid === 1'b1) {g_wbv, g_wb} = {1'b1, wr_wb.value};
            if (rd_valid === 1'b1) g_data = rd_data;
            @(posedge ref_clk);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_word;
        acc(1, 0, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h0901, 16'ha55a);
        acc(0, 0, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h0900, 16'h0000);
        check(g_data, 16'ha55a);
        check({12'h000, g_bus}, 16'h0001);
        $display("test word done");
    endtask
    task automatic t_bytes;
        acc(1, 0, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h0902, 16'h1122);
        acc(1, 1, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h0903, 16'h003c);
        acc(0, 0, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h0902, 16'h0000);
        check(g_data, 16'h3c22);
        acc(0, 1, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h0903, 16'h0000);
        check(g_data, 16'h003c);
        acc(0, 1, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h0902, 16'h0000);
        check(g_data, 16'h0022);
        $display("test bytes done");
    endtask
    task automatic t_pointer;
        wreg_file[16*5 +: 16] <= 16'h0900;
        wreg_file[16*9 +: 16] <= 16'h0904;
        acc(0, 0, dsag_pkg::DSAG_AM_POSTINC, 5, 16'h0000, 16'h0000);
        check(g_data, 16'ha55a);
        check(g_wb, 16'h0902);
        acc(1, 1, dsag_pkg::DSAG_AM_POSTDEC, 9, 16'h0000, 16'h0077);
        check(g_wb, 16'h0903);
        acc(0, 0, dsag_pkg::DSAG_AM_PREINC, 5, 16'h0000, 16'h0000);
        check(g_data, 16'h3c22);
        check(g_wb, 16'h0902);
        acc(0, 1, dsag_pkg::DSAG_AM_PREDEC, 9, 16'h0000, 16'h0000);
        check(g_wb, 16'h0903);
        acc(0, 0, dsag_pkg::DSAG_AM_IND, 5, 16'h0000, 16'h0000);
        check(g_data, 16'ha55a);
        $display("test pointer done");
    endtask
    task automatic t_sfr;
        acc(1, 0, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h0010, 16'hbeef);
        check({12'h000, g_bus}, 16'h0008);
        acc(0, 0, dsag_pkg::DSAG_AM_NEAR, 0, 16'he010, 16'h0000);
        check(g_data, 16'hbeef);
        check({12'h000, g_bus}, 16'h0004);
        $display("test sfr done");
    endtask
    task automatic t_trap;
        wreg_file[16*3 +: 16] <= 16'h8000;
        acc(0, 0, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h4000, 16'h0000);
        check(g_data, 16'h0000);
        check({15'h0000, g_trap}, 16'h0001);
        acc(1, 0, dsag_pkg::DSAG_AM_POSTINC, 3, 16'h0000, 16'h1234);
        check({11'h000, g_bus, g_wbv}, 16'h0000);
        check({15'h0000, g_trap}, 16'h0001);
        $display("test trap done");
    endtask
    task automatic t_dpr;
        fork
            acc(1, 0, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h1800, 16'h1234);
            begin
                repeat (2) @(posedge ref_clk);
                dma_bus <= '{1'b0, 1'b1, 16'h1802, 2'b11, 16'h5678};
                @(posedge ref_clk);
                dma_bus <= '0;
            end
        join
        fork
            acc(0, 0, dsag_pkg::DSAG_AM_DIRECT, 0, 16'h1802, 16'h0000);
            begin
                repeat (2) @(posedge ref_clk);
                dma_bus <= '{1'b1, 1'b0, 16'h1800, 2'b11, 16'h0000};
                @(posedge ref_clk);
                dma_bus <= '0;
                #1;
                check(dma_rdata, 16'h1234);
            end
        join
        check(g_data, 16'h5678);
        $display("test dual port done");
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_word();
        t_bytes();
        t_pointer();
        t_sfr();
        t_trap();
        t_dpr();
        report_and_stop();
    end
    initial begin
        #20000;
        mismatches++;
        report_and_stop();
    end
endmodule
